// >>> common/reset_cause_pkg.sv
// Purpose: Shared constants for the reset cause recorder.
// Assumes: One 20 MHz system clock.
// Notes: Option byte addresses are flash byte addresses.
package reset_cause_pkg;
    localparam int CauseWidth = 8;
    localparam int TrapBit = 7;
    localparam int WatchdogBit = 4;
    localparam int SupplyBit = 0;
    localparam logic [7:0] CauseReset = 8'h00;
    localparam logic [7:0] IllegalOpcode = 8'hFF;
    localparam logic [17:0] OptByteFirst = 18'h0_00C0;
    localparam logic [17:0] OptByteSupply = 18'h0_00C1;
    localparam int OptByteCount = 4;
    localparam int LevelLsb = 2;
    localparam int LevelWidth = 2;
    localparam int OcdEnableBit = 7;
    localparam logic [7:0] OptByteReset = 8'hFF;
    typedef enum logic [1:0] {
        LOAD_ADDR,
        LOAD_WAIT,
        RUN
    } load_state_t;
endpackage : reset_cause_pkg

// >>> design/option_byte_store.sv
// Purpose: Holds the four configuration bytes read at reset.
// Assumes: One byte written every second cycle during the load sequence.
// Notes: Read data comes from a register.
`timescale 1ns/100ps
`default_nettype none
module option_byte_store
    import reset_cause_pkg::*;
(
    input wire logic clock, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic writeEn, // Store a byte.
    input wire logic [1:0] writeIdx, // Byte index.
    input wire logic [7:0] writeData, // Byte value.
    input wire logic [1:0] readIdx, // Byte index to read.
    output logic [7:0] readData // Registered read data.
);
    logic [7:0] mem_r [OptByteCount];
    logic [7:0] readData_nxt;

    // Read path is registered so the store looks like a small memory.
    always_comb begin
        readData_nxt = mem_r[readIdx];
    end

    // Each entry takes its byte when selected.
    for (genvar i = 0; i < OptByteCount; i++) begin : g_entry
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                mem_r[i] <= OptByteReset;
            end else if (writeEn && writeIdx == 2'(i)) begin
                mem_r[i] <= writeData;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            readData <= OptByteReset;
        end else begin
            readData <= readData_nxt;
        end
    end
endmodule : option_byte_store
`default_nettype wire

// >>> design/reset_cause_recorder.sv
// Purpose: Records the cause of the latest internal reset and runs the supply monitor.
// Assumes: Supply comparisons arrive as synchronous level inputs; flash answers in one cycle.
// Notes: rst_n is the external reset input and also the data-retention loss reset.
//
// Function
// - Cause byte: opcode trap bit 7, watchdog bit 4, supply bit 0, rest zero.
// - Cause byte is read only whole; writes have no effect.
// - A byte read returns flags then clears all three.
// - External reset or data-retention loss clears all three flags.
// - Executing opcode FFH resets and sets the trap flag, others held.
// - No opcode trap reset while an emulator or debugger is attached.
// - Watchdog reset sets watchdog flag, other flags held.
// - Supply monitor reset sets supply flag, other flags held.
// - Flags survive internal resets while supply stays above retention limit.
// - Power-up reset held until supply exceeds selected rise level.
// - Reset asserted whenever supply drops below selected fall level.
// - Threshold pair chosen among four levels by a field of byte 000C1H.
// - Configuration bytes 000C0H to 000C3H loaded on power-up and every reset.
`timescale 1ns/100ps
`default_nettype none
module reset_cause_recorder
    import reset_cause_pkg::*;
(
    input wire logic clock, // System clock, 20 MHz.
    input wire logic rst_n, // External reset or retention loss, active low.
    input wire logic causeRead, // Byte-wide read strobe of the cause register.
    output logic [7:0] causeData, // Registered cause byte read data.
    input wire logic opcodeValid, // An opcode is being executed.
    input wire logic [7:0] opcodeByte, // The opcode byte being executed.
    input wire logic debugActive, // Emulator or on-chip debugger attached.
    input wire logic watchdogOverflow, // Watchdog unit overflow pulse.
    input wire logic [3:0] supplyAboveRise, // Rise comparators, one per level.
    input wire logic [3:0] supplyBelowFall, // Fall comparators, one per level.
    output logic [17:0] flashAddr, // Configuration byte address.
    output logic flashRead, // Configuration byte read strobe.
    input wire logic [7:0] flashData, // Configuration byte, one cycle later.
    output logic internalReset, // Internal reset to the core, active high.
    output logic [1:0] supplyLevel, // Applied supply threshold selection.
    output logic debugEnable // Applied on-chip debug enable.
);
    logic [7:0] cause_r;
    logic [7:0] cause_nxt;
    logic [7:0] causeData_nxt;
    load_state_t state_r;
    load_state_t state_nxt;
    logic [1:0] idx_r;
    logic [1:0] idx_nxt;
    logic powerGood_r;
    logic powerGood_nxt;
    logic internalReset_nxt;
    logic [17:0] flashAddr_nxt;
    logic flashRead_nxt;
    logic [1:0] supplyLevel_nxt;
    logic debugEnable_nxt;
    logic [7:0] storeData;
    logic [1:0] level;
    logic trapHit;
    logic supplyTrip;
    logic coreReset;

    // The store keeps the loaded bytes; byte 1 carries the level, byte 3 debug.
    option_byte_store u_store (
        .clock(clock),
        .rst_n(rst_n),
        .writeEn(state_r == LOAD_WAIT),
        .writeIdx(idx_r),
        .writeData(flashData),
        .readIdx(OptByteSupply[1:0]),
        .readData(storeData)
    );

    // level field
    // Level is taken from the applied copy so a reload cannot glitch it.
    assign level = supplyLevel;

    // debug suppression
    // The trap only fires outside debug so breakpoints on FFH stay usable.
    assign trapHit = opcodeValid && (opcodeByte == IllegalOpcode) && !debugActive;

    assign supplyTrip = powerGood_r && supplyBelowFall[level];

    // Any of these restarts the core; each also sets its own flag in the record.
    assign coreReset = trapHit || watchdogOverflow || supplyTrip;

    // Cause flags: set wins over the clear from a read in the same cycle.
    always_comb begin
        cause_nxt = cause_r;
        if (causeRead) begin
            cause_nxt = CauseReset;
        end
        if (trapHit) begin
            cause_nxt[TrapBit] = 1'b1;
        end
        if (watchdogOverflow) begin
            cause_nxt[WatchdogBit] = 1'b1;
        end
        if (supplyTrip) begin
            cause_nxt[SupplyBit] = 1'b1;
        end
        cause_nxt = cause_nxt & ((8'h01 << TrapBit) | (8'h01 << WatchdogBit) | (8'h01 << SupplyBit));
        causeData_nxt = causeRead ? cause_r : causeData;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cause_r <= CauseReset;
            causeData <= CauseReset;
        end else begin
            cause_r <= cause_nxt;
            causeData <= causeData_nxt;
        end
    end

    // Load sequencer and supply monitor; reset held until both are done.
    always_comb begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        powerGood_nxt = powerGood_r;
        flashRead_nxt = 1'b0;
        flashAddr_nxt = flashAddr;
        supplyLevel_nxt = supplyLevel;
        debugEnable_nxt = debugEnable;
        case (state_r)
            LOAD_ADDR: begin
                flashRead_nxt = 1'b1;
                flashAddr_nxt = OptByteFirst + 18'(idx_r);
                state_nxt = LOAD_WAIT;
            end
            LOAD_WAIT: begin
                if (idx_r == 2'(OptByteCount - 1)) begin
                    // level applied
                    // The level byte comes back from the store, so both settings switch together.
                    supplyLevel_nxt = storeData[LevelLsb +: LevelWidth];
                    debugEnable_nxt = flashData[OcdEnableBit];
                    state_nxt = RUN;
                end else begin
                    state_nxt = LOAD_ADDR;
                end
                idx_nxt = idx_r + 2'd1;
            end
            RUN: begin
                if (!powerGood_r && supplyAboveRise[level]) begin
                    powerGood_nxt = 1'b1;
                end
                // Any core reset re-reads the configuration before running.
                if (coreReset) begin
                    state_nxt = LOAD_ADDR;
                    idx_nxt = 2'd0;
                    powerGood_nxt = !supplyTrip;
                end
            end
            default: begin
                state_nxt = LOAD_ADDR;
                idx_nxt = 2'd0;
            end
        endcase
        internalReset_nxt = (state_nxt != RUN) || !powerGood_nxt;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= LOAD_ADDR;
            idx_r <= 2'd0;
            powerGood_r <= 1'b0;
            internalReset <= 1'b1;
            flashAddr <= OptByteFirst;
            flashRead <= 1'b0;
            supplyLevel <= 2'b00;
            debugEnable <= 1'b0;
        end else begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            powerGood_r <= powerGood_nxt;
            internalReset <= internalReset_nxt;
            flashAddr <= flashAddr_nxt;
            flashRead <= flashRead_nxt;
            supplyLevel <= supplyLevel_nxt;
            debugEnable <= debugEnable_nxt;
        end
    end
endmodule : reset_cause_recorder
`default_nettype wire

// >>> bench/reset_cause_props.sv
// Purpose: Port assertions for the reset cause recorder.
// Assumes: One clock; rst_n asynchronous, active low.
// Notes: Bound to the design after the module.
`timescale 1ns/100ps
`default_nettype none
module reset_cause_props
    import reset_cause_pkg::*;
(
    input wire logic clock, // Clock.
    input wire logic rst_n, // Reset.
    input wire logic causeRead, // Read strobe.
    input wire logic [7:0] causeData, // Read data.
    input wire logic opcodeValid, // Opcode valid.
    input wire logic [7:0] opcodeByte, // Opcode.
    input wire logic debugActive, // Debugger on.
    input wire logic watchdogOverflow, // Watchdog pulse.
    input wire logic [3:0] supplyAboveRise, // Rise levels.
    input wire logic [3:0] supplyBelowFall, // Fall levels.
    input wire logic [17:0] flashAddr, // Fetch address.
    input wire logic flashRead, // Fetch strobe.
    input wire logic internalReset, // Core reset.
    input wire logic [1:0] supplyLevel // Applied level.
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // A trap only counts while the core runs, so reset time is kept out of it.
    logic trapNow;
    logic anyEvent;
    assign trapNow = opcodeValid && opcodeByte == IllegalOpcode && !internalReset;
    // The recorder takes an FFH trap even while the core is held, so any FFH counts here.
    assign anyEvent = (opcodeValid && opcodeByte == IllegalOpcode) || watchdogOverflow
        || supplyBelowFall[supplyLevel];
    a_spare_bits_zero: assert property (causeData[6:5] == 2'b00 && causeData[3:1] == 3'b000)
        else $error("cause byte spare bits set");
    a_byte_stands: assert property (!causeRead |=> $stable(causeData))
        else $error("cause byte changed without a read");
    a_read_clears: assert property (causeRead && !anyEvent ##1 causeRead && !anyEvent |=> causeData == 8'h00)
        else $error("second read not zero");
    a_trap_resets: assert property (trapNow && !debugActive |-> ##[1:2] internalReset)
        else $error("trap gave no reset");
    a_debug_no_trap: assert property (trapNow && debugActive && !watchdogOverflow && !supplyBelowFall[supplyLevel] |=> !internalReset)
        else $error("trap reset under debugger");
    a_watchdog_resets: assert property (watchdogOverflow && !internalReset |-> ##[1:2] internalReset)
        else $error("watchdog gave no reset");
    a_fall_resets: assert property (!internalReset && supplyBelowFall[supplyLevel] |-> ##[1:2] internalReset)
        else $error("supply fall gave no reset");
    a_rise_holds: assert property (internalReset && !supplyAboveRise[supplyLevel] |=> internalReset)
        else $error("reset released below rise level");
    a_fetch_order: assert property (flashRead && flashAddr != 18'h0_00C3 |-> ##2 flashRead && flashAddr == $past(flashAddr, 2) + 18'h0_0001)
        else $error("configuration fetch out of order");
    c_trap: cover property (trapNow && !debugActive);
    c_watchdog: cover property (watchdogOverflow && !internalReset);
    c_double_read: cover property (causeRead ##1 causeRead);
endmodule : reset_cause_props
bind reset_cause_recorder reset_cause_props reset_cause_props_inst (.clock(clock), .rst_n(rst_n),
    .causeRead(causeRead), .causeData(causeData), .opcodeValid(opcodeValid),
    .opcodeByte(opcodeByte), .debugActive(debugActive), .watchdogOverflow(watchdogOverflow),
    .supplyAboveRise(supplyAboveRise), .supplyBelowFall(supplyBelowFall), .flashAddr(flashAddr),
    .flashRead(flashRead), .internalReset(internalReset), .supplyLevel(supplyLevel));
`default_nettype wire

// >>> bench/tb_top.sv
// Purpose: Self-checking bench for the reset cause recorder.
// Assumes: Inputs change on the falling edge.
// Notes: Rows hold {opcode, debug, watchdog, fall comparators}.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clock, rst_n, causeRead, opcodeValid, debugActive, watchdogOverflow;
    logic flashRead, internalReset, debugEnable;
    logic [7:0] causeData, opcodeByte, flashData;
    logic [3:0] supplyAboveRise, supplyBelowFall;
    logic [17:0] flashAddr;
    logic [1:0] supplyLevel;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [7:0] optByte [4] = '{8'hFF, 8'hEB, 8'hF9, 8'h85};
    logic [13:0] rowIn [6] = '{14'h3FC0, 14'h0010, 14'h3FE0, 14'h3F80, 14'h0004, 14'h000B};
    logic [7:0] rowExp [6] = '{8'h80, 8'h10, 8'h00, 8'h00, 8'h01, 8'h00};
    reset_cause_recorder reset_cause_recorder_inst (.clock(clock), .rst_n(rst_n),
        .causeRead(causeRead), .causeData(causeData), .opcodeValid(opcodeValid),
        .opcodeByte(opcodeByte), .debugActive(debugActive), .watchdogOverflow(watchdogOverflow),
        .supplyAboveRise(supplyAboveRise), .supplyBelowFall(supplyBelowFall),
        .flashAddr(flashAddr), .flashRead(flashRead), .flashData(flashData),
        .internalReset(internalReset), .supplyLevel(supplyLevel), .debugEnable(debugEnable));
    // Half-period toggle gives the 50 ns clock.
    always #25 clock = ~clock;
    // The flash answers one cycle after a fetch and holds until the next one.
    always @(negedge clock) begin
        if (flashRead) begin
            flashData <= optByte[flashAddr[1:0]];
        end
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask : check
    task automatic complete_run();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    // Bounded wait for the core reset to drop after a fetch.
    task automatic settle();
        repeat (3) @(negedge clock);
        for (int i = 0; i < 100 && internalReset !== 1'b0; i++) @(negedge clock);
        if (internalReset !== 1'b0) begin
            n_mismatch++;
            complete_run();
        end
    endtask : settle
    task automatic kick(input logic [13:0] r);
        @(negedge clock);
        {opcodeByte, debugActive, watchdogOverflow, supplyBelowFall} = r;
        opcodeValid = 1'b1;
        @(negedge clock);
        {opcodeByte, debugActive, watchdogOverflow, supplyBelowFall} = 14'h0000;
        opcodeValid = 1'b0;
        settle();
    endtask : kick
    // whole-byte reads only
    // Two back-to-back reads: flags first, then the cleared byte.
    task automatic read_pair(input logic [7:0] exp);
        @(negedge clock);
        causeRead = 1'b1;
        @(negedge clock);
        check("cause", exp, causeData);
        @(negedge clock);
        causeRead = 1'b0;
        check("cleared", 8'h00, causeData);
    endtask : read_pair
    // Main sequence: reset, table rows, then accumulation, race and pin reset.
    initial begin
        {clock, rst_n, causeRead, opcodeValid, debugActive, watchdogOverflow} = 6'h00;
        {opcodeByte, supplyAboveRise, supplyBelowFall} = 16'h0000;
        repeat (8) @(negedge clock);
        check("held reset", 8'h01, {7'h00, internalReset});
        check("reset cause", 8'h00, causeData);
        rst_n = 1'b1;
        repeat (30) @(negedge clock);
        check("below rise", 8'h01, {7'h00, internalReset});
        supplyAboveRise = 4'h4;
        settle();
        check("level", 8'h02, {6'h00, supplyLevel});
        check("debug enable", 8'h01, {7'h00, debugEnable});
        for (int k = 0; k < 6; k++) begin
            kick(rowIn[k]);
            read_pair(rowExp[k]);
        end
        kick(14'h3FC0);
        kick(14'h0010);
        kick(14'h0004);
        read_pair(8'h91);
        @(negedge clock);
        {causeRead, watchdogOverflow} = 2'b11;
        @(negedge clock);
        {causeRead, watchdogOverflow} = 2'b00;
        check("read race", 8'h00, causeData);
        settle();
        read_pair(8'h10);
        kick(14'h3FC0);
        // A new level byte must take effect on the next load.
        optByte[1] = 8'hE3;
        supplyAboveRise = 4'h1;
        rst_n = 1'b0;
        @(negedge clock);
        rst_n = 1'b1;
        settle();
        check("new level", 8'h00, {6'h00, supplyLevel});
        read_pair(8'h00);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
